//--- wake_and_phy_reset_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module wake_and_phy_reset_control_tb_top
  import wpc_pkg::*;
;
  localparam int LEN = 8; // short hold keeps the run brief
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        suspend_entry = 1'b0;
  logic        resume_done = 1'b0;
  logic        resume_remote = 1'b0;
  logic        energy_detect_event = 1'b0;
  logic        lan_wake_event = 1'b0;
  logic        dev_ready = 1'b1;
  logic        slow = 1'b0; // host offers every other cycle
  logic [31:0] rdata;
  logic        phy_reset;
  logic        usb_nak_all;
  logic [1:0]  suspend_mode;
  logic        irq;
  int          nak_cnt;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          phy_cnt = 0; // edges seen with phy held
  int          n;
  logic [31:0] seed = 32'h143fe982;
  logic [1:0]  en;
  logic [31:0] cw; // control word of this pass
  logic        hit;
  // reference model of the control word and interrupt state
  logic [1:0]  m_sts, m_mode, m_irq, m_ien;
  logic        m_ed, m_lan, m_phy, m_cen, m_csts;

  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
    if (phy_reset === 1'b1)
      phy_cnt <= phy_cnt + 1;

  wpc_top #(.PHY_RST_LEN(LEN)) dut
  (
    .sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .suspend_entry,
    .resume_done, .resume_remote, .energy_detect_event, .lan_wake_event,
    .dev_ready, .phy_reset, .usb_nak_all, .suspend_mode, .irq
  );
  wpc_host_model host (.sys_clk, .usb_nak_all, .slow, .nak_cnt);

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] img();
    return {22'h0, m_csts, m_cen, dev_ready, m_mode, m_phy, m_lan, m_ed,
            m_sts};
  endfunction
  task automatic chk_read(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_pin(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", s, e, g);
    end
  endtask
  // one-cycle bus strobes, released at the edge that takes them
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk_read("rdata", e, rdata);
  endtask
  // control write with the model following it
  task automatic wctl(input logic [31:0] d);
    wreg(OFS_POWER_MGMT_CONTROL, d);
    m_sts = m_sts & ~d[1:0];
    {m_csts, m_cen, m_mode, m_lan, m_ed} = {d[9:8], d[6:5], d[3:2]};
    m_phy = m_phy | d[4];
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: suspend_entry <= 1'b1;
      1: energy_detect_event <= 1'b1;
      2: lan_wake_event <= 1'b1;
      default:
      begin
        resume_done   <= 1'b1;
        resume_remote <= seed[2]; // remote or host resume
      end
    endcase
    @(posedge sys_clk);
    {suspend_entry, energy_detect_event, lan_wake_event, resume_done}
      <= 4'h0;
  endtask
  // model state right after a reset
  task automatic mreset();
    {m_sts, m_ed, m_lan, m_phy, m_csts, m_irq, m_ien} = 10'h000;
    m_mode = RST_MODE;
    m_cen = RST_CLR_EN;
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under 1000 cycles
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    $display("mismatch watchdog expected end seen timeout");
    print_verdict();
  end

  initial
  begin
    mreset();
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rreg(OFS_POWER_MGMT_CONTROL, img());
    chk_pin("suspend_mode", 2'h2, suspend_mode);
    rreg(8'h3c, 32'h0);
    $display("test reset done");
    // phy reset, retriggered while busy
    n = nak_cnt;
    wctl(32'h110);
    wctl(32'h110);
    rreg(OFS_POWER_MGMT_CONTROL, img());
    repeat (LEN + 2) @(posedge sys_clk);
    m_phy = 1'b0;
    m_irq[0] = 1'b1;
    chk_pin("phy_hold", LEN, phy_cnt);
    chk_pin("naks", LEN, nak_cnt - n);
    rreg(OFS_POWER_MGMT_CONTROL, img());
    rreg(OFS_IRQ_STATUS, {30'h0, m_irq});
    wreg(OFS_IRQ_ENABLE, 32'h3);
    m_ien = 2'h3;
    rreg(OFS_IRQ_ENABLE, 32'h3);
    chk_pin("irq", 1, irq);
    $display("test phy reset done");
    // every variant against both wake sources
    for (int m = 0; m < 4; m++)
      for (int k = 1; k < 3; k++)
      begin
        seed = lfsr(seed);
        en = seed[1:0];
        cw = {22'h0, seed[3], seed[4], 1'b0, m[1:0], 1'b0, en, 2'h0};
        wctl(cw);
        chk_pin("suspend_mode", m, suspend_mode);
        wctl(cw | 32'h3);
        pulse(k);
        pulse(0);
        pulse(k);
        hit = (k == 1) ? (en[0] && m == 1) : (en[1] && (m == 0 || m == 3));
        if (hit)
        begin
          m_sts[k-1] = 1'b1;
          m_irq[1] = 1'b1;
        end
        rreg(OFS_POWER_MGMT_CONTROL, img());
        pulse(3);
        if (seed[2] && m_cen)
          {m_ed, m_lan} = 2'h0;
        if (m_csts)
          m_sts[1] = 1'b0;
        rreg(OFS_POWER_MGMT_CONTROL, img());
      end
    $display("test wake done");
    // slow host: only every other transfer is offered and naked
    slow = 1'b1;
    n = nak_cnt;
    wctl(32'h110);
    repeat (LEN + 2) @(posedge sys_clk);
    m_phy = 1'b0;
    m_irq[0] = 1'b1;
    chk_pin("naks_slow", LEN / 2, nak_cnt - n);
    rreg(OFS_POWER_MGMT_CONTROL, img());
    rreg(OFS_IRQ_STATUS, {30'h0, m_irq});
    wreg(OFS_IRQ_CLEAR, 32'h3);
    m_irq = 2'h0;
    rreg(OFS_IRQ_STATUS, {30'h0, m_irq});
    rreg(OFS_IRQ_CLEAR, 32'h0);
    chk_pin("irq", 0, irq);
    $display("test slow host done");
    // reset again in the middle of a phy hold
    wctl(32'h110);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    mreset();
    #1;
    chk_pin("phy_reset", 0, phy_reset);
    chk_pin("naks_reset", 0, usb_nak_all);
    rreg(OFS_POWER_MGMT_CONTROL, img());
    rreg(OFS_IRQ_STATUS, 32'h0);
    chk_pin("irq", 0, irq);
    $display("test mid reset done");
    print_verdict();
  end
endmodule // wake_and_phy_reset_control_tb_top
`default_nettype wire

//--- wpc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// usb host across the link: offers one transfer a cycle, or every
// other cycle when slow, and tallies the ones answered with a nak
module wpc_host_model
(
  // clock
  input  wire logic sys_clk,
  // link state
  input  wire logic usb_nak_all,
  input  wire logic slow,
  // tally
  output var  int   nak_cnt
);
  logic odd   = 1'b0; // alternate offers when slow
  int   tally = 0;    // naks handed out so far

  assign nak_cnt = tally;

  // an offer while naks are forced is refused and counted
  always @(posedge sys_clk)
  begin
    odd <= ~odd;
    if ((!slow || odd) && usb_nak_all === 1'b1)
      tally <= tally + 1;
  end
endmodule // wpc_host_model
`default_nettype wire

//--- wpc_pkg.sv
// Function
// - phy reset bit holds phy reset 2 ms
// - phy reset bit self-clears, resets to zero
// - writes to bit ignored while it is one
// - nak every usb transfer during phy reset
// - two wake enables, both reset to zero
// - resume-clears-enables clears both wake enables
// - two-bit wake cause encoding per variant
// - status bits independent, write one clears
// - status set only if enabled before suspend
// - resume-clears-status clears upper status bit
// - suspend mode selects variant, resets to 10
// - only remote-wake resumes clear the enables
`default_nettype none
package wpc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_POWER_MGMT_CONTROL = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS         = 8'h30;
  localparam logic [7:0] OFS_IRQ_CLEAR          = 8'h34;
  localparam logic [7:0] OFS_IRQ_ENABLE         = 8'h38;
  // power_mgmt_control field positions
  localparam int POS_STATUS_LO  = 0;
  localparam int POS_STATUS_HI  = 1;
  localparam int POS_ENERGY_DETECT_WAKE_ENABLE      = 2;
  localparam int POS_LAN_EN     = 3;
  localparam int POS_PHY_RST    = 4;
  localparam int POS_MODE_LO    = 5;
  localparam int POS_MODE_HI    = 6;
  localparam int POS_READY      = 7;
  localparam int POS_CLR_EN     = 8;
  localparam int POS_CLR_STS    = 9;
  // reset values
  localparam logic [1:0] RST_MODE    = 2'h2;
  localparam logic       RST_CLR_EN  = 1'h1;
  localparam logic       RST_CLR_STS = 1'h0;
  // suspend variant encodings
  localparam logic [1:0] LOW_POWER_VARIANT_ZERO  = 2'h0;
  localparam logic [1:0] LOW_POWER_VARIANT_ONE   = 2'h1;
  localparam logic [1:0] LOW_POWER_VARIANT_TWO   = 2'h2;
  localparam logic [1:0] LOW_POWER_VARIANT_THREE = 2'h3;
  // interrupt event bits
  localparam int IRQ_PHY_DONE = 0;
  localparam int IRQ_WAKE     = 1;
  // timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int PHY_RST_MIN_NS = 2000000;
  localparam int PHY_RST_CYCLES =
    (PHY_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // phy reset sequencer states
  typedef enum logic [0:0] {
    PR_IDLE = 1'b0,
    PR_HOLD = 1'b1
  } wpc_phy_state_t;
endpackage
`default_nettype wire

//--- wpc_top.sv
`timescale 1ns/100ps
`default_nettype none
module wpc_top
  import wpc_pkg::*;
#(
  parameter int PHY_RST_LEN = PHY_RST_CYCLES // hold length in clocks
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  // power state events
  input  wire logic        suspend_entry,
  input  wire logic        resume_done,
  input  wire logic        resume_remote,
  input  wire logic        energy_detect_event,
  input  wire logic        lan_wake_event,
  input  wire logic        dev_ready,
  // phy and usb control
  output var  logic        phy_reset,
  output var  logic        usb_nak_all,
  output var  logic [1:0]  suspend_mode,
  // interrupt
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////
  // decode
  localparam logic [15:0] HOLD_LAST = 16'(PHY_RST_LEN - 1);

  logic ctrl_wr;                    // write to control register
  logic ctrl_rd;                    // read of control register
  assign ctrl_wr = wr && (addr == OFS_POWER_MGMT_CONTROL);
  assign ctrl_rd = rd && (addr == OFS_POWER_MGMT_CONTROL);

  ////////////////////////////////////////////////////////////////////
  // phy reset sequencer
  wpc_phy_state_t state;            // current sequencer state
  wpc_phy_state_t next_state;       // next sequencer state
  logic [15:0]    hold_cnt;         // clocks spent in reset
  logic           phy_done;         // one-cycle end of reset

  // start only from idle, so a busy bit swallows the write
  always_comb
  begin
    next_state = state;
    phy_done   = 1'b0;
    case (state)
      PR_IDLE:
      begin
        if (ctrl_wr && wdata[POS_PHY_RST])
          next_state = PR_HOLD;
      end
      PR_HOLD:
      begin
        // writes here are dropped
        if (hold_cnt == HOLD_LAST)
        begin
          next_state = PR_IDLE;
          phy_done   = 1'b1;
        end
      end
      default:
        next_state = PR_IDLE;
    endcase
  end

  // state and hold counter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state    <= PR_IDLE;
      hold_cnt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (state == PR_HOLD)
        hold_cnt <= hold_cnt + 16'h0001;
      else
        hold_cnt <= 16'h0000;
    end
  end

  // pins follow the next state so they stay pure flops
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      phy_reset   <= 1'b0;
      usb_nak_all <= 1'b0;
    end
    else
    begin
      phy_reset   <= (next_state == PR_HOLD);
      usb_nak_all <= (next_state == PR_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control fields
  logic lan_wake_enable;            // wake-on-lan source enable
  logic energy_detect_wake_enable;  // energy-detect source enable
  logic resume_clears_wake_enables; // remote-wake resume wipes enables
  logic resume_clears_wake_status;  // resume wipes upper status
  logic remote_resume_done;         // remote-wake resume finished

  assign remote_resume_done = resume_done && resume_remote;

  // mode and resume controls are plain read/write
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      suspend_mode               <= RST_MODE;
      resume_clears_wake_enables <= RST_CLR_EN;
      resume_clears_wake_status  <= RST_CLR_STS;
    end
    else if (ctrl_wr)
    begin
      suspend_mode <= wdata[POS_MODE_HI:POS_MODE_LO];
      resume_clears_wake_enables <= wdata[POS_CLR_EN];
      resume_clears_wake_status  <= wdata[POS_CLR_STS];
    end
  end

  // a software write wins over the resume clear: it is newer intent
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lan_wake_enable           <= 1'b0;
      energy_detect_wake_enable <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      lan_wake_enable           <= wdata[POS_LAN_EN];
      energy_detect_wake_enable <= wdata[POS_ENERGY_DETECT_WAKE_ENABLE];
    end
    else if (remote_resume_done && resume_clears_wake_enables)
    begin
      // host resumes leave enables alone
      lan_wake_enable           <= 1'b0;
      energy_detect_wake_enable <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wake arming and cause status
  logic       in_low_power;         // between suspend and resume
  logic       lan_armed;            // lan enable seen at suspend
  logic       ed_armed;             // energy enable seen at suspend
  logic [1:0] wakeup_cause_status;  // bit1 lan/frame, bit0 energy
  logic [1:0] status_set;           // hardware set terms
  logic [1:0] status_clr;           // software and resume clears

  // enables are sampled on entry so late changes cannot arm
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      in_low_power <= 1'b0;
      lan_armed    <= 1'b0;
      ed_armed     <= 1'b0;
    end
    else if (suspend_entry)
    begin
      in_low_power <= 1'b1;
      lan_armed    <= lan_wake_enable;
      ed_armed     <= energy_detect_wake_enable;
    end
    else if (resume_done)
      in_low_power <= 1'b0;
  end

  // cause bits per variant: energy in one, lan in zero and three
  always_comb
  begin
    status_set[0] = in_low_power && ed_armed && energy_detect_event
      && (suspend_mode == LOW_POWER_VARIANT_ONE);
    status_set[1] = in_low_power && lan_armed && lan_wake_event
      && ((suspend_mode == LOW_POWER_VARIANT_ZERO)
       || (suspend_mode == LOW_POWER_VARIANT_THREE));
    status_clr[0] = ctrl_wr && wdata[POS_STATUS_LO];
    status_clr[1] = (ctrl_wr && wdata[POS_STATUS_HI])
      || (resume_done && resume_clears_wake_status);
  end

  // set beats clear, so a coincident wake is never lost
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wakeup_cause_status <= 2'h0;
    else
      wakeup_cause_status <=
        (wakeup_cause_status & ~status_clr) | status_set;
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt registers
  logic [1:0] irq_status;           // sticky event bits
  logic [1:0] irq_enable;           // event gating
  logic [1:0] irq_events;           // this cycle's events
  logic [1:0] irq_clr;              // write-one-clear mask
  logic [1:0] next_irq_status;      // updated sticky bits
  logic [1:0] next_irq_enable;      // enable after this cycle's write

  always_comb
  begin
    irq_events[IRQ_PHY_DONE] = phy_done;
    irq_events[IRQ_WAKE]     = |status_set;
    irq_clr = (wr && (addr == OFS_IRQ_CLEAR)) ? wdata[1:0] : 2'h0;
    next_irq_enable = (wr && (addr == OFS_IRQ_ENABLE)) ? wdata[1:0]
      : irq_enable;
    next_irq_status = (irq_status & ~irq_clr) | irq_events;
  end

  // sticky status and enable; output is registered from next value
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_status <= 2'h0;
      irq_enable <= 2'h0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      // next values, so irq follows an enable write with no lag
      irq <= |(next_irq_status & next_irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data, valid the cycle after the strobe only
  logic [31:0] ctrl_view;           // control register image

  always_comb
  begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[POS_STATUS_HI:POS_STATUS_LO] = wakeup_cause_status;
    ctrl_view[POS_ENERGY_DETECT_WAKE_ENABLE]   = energy_detect_wake_enable;
    ctrl_view[POS_LAN_EN]  = lan_wake_enable;
    ctrl_view[POS_PHY_RST] = (state == PR_HOLD);
    ctrl_view[POS_MODE_HI:POS_MODE_LO] = suspend_mode;
    ctrl_view[POS_READY]   = dev_ready;
    ctrl_view[POS_CLR_EN]  = resume_clears_wake_enables;
    ctrl_view[POS_CLR_STS] = resume_clears_wake_status;
  end

  // unmapped and write-only offsets read zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      case (addr)
        OFS_POWER_MGMT_CONTROL: rdata <= ctrl_view;
        OFS_IRQ_STATUS:         rdata <= {30'h0, irq_status};
        OFS_IRQ_ENABLE:         rdata <= {30'h0, irq_enable};
        default:                rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  a_phy_hold_len: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(phy_reset) |-> ($past(hold_cnt) == HOLD_LAST))
    else $error("phy reset released early");

  a_phy_start: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_wr && wdata[POS_PHY_RST] && !phy_reset) |=> phy_reset)
    else $error("phy reset did not start");

  // a restart would zero the counter, so it must keep counting
  a_busy_write_ignored: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_wr && wdata[POS_PHY_RST] && phy_reset) |=>
      (!phy_reset || hold_cnt == $past(hold_cnt) + 16'h0001))
    else $error("phy reset restarted while busy");

  a_nak_with_reset: assert property (
    @(posedge sys_clk) disable iff (rst)
    usb_nak_all == phy_reset)
    else $error("nak not matching phy reset");

  a_read_phy_bit: assert property (
    @(posedge sys_clk) disable iff (rst)
    ctrl_rd |=> rdata[POS_PHY_RST] == $past(phy_reset))
    else $error("phy reset bit readback wrong");

  a_remote_resume_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    (remote_resume_done && resume_clears_wake_enables && !ctrl_wr) |=>
      (!lan_wake_enable && !energy_detect_wake_enable))
    else $error("enables survived remote resume");

  a_host_resume_keeps: assert property (
    @(posedge sys_clk) disable iff (rst)
    (resume_done && !resume_remote && !ctrl_wr) |=>
      $stable(lan_wake_enable) && $stable(energy_detect_wake_enable))
    else $error("host resume changed enables");

  a_status_w1c: assert property (
    @(posedge sys_clk) disable iff (rst)
    (status_clr[0] && !status_set[0]) |=> !wakeup_cause_status[0])
    else $error("status bit not cleared");

  a_unarmed_no_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    !lan_armed |=> !$rose(wakeup_cause_status[1]))
    else $error("unarmed wake set status");

  a_resume_status_clr: assert property (
    @(posedge sys_clk) disable iff (rst)
    (resume_done && resume_clears_wake_status && !status_set[1]) |=>
      !wakeup_cause_status[1])
    else $error("upper status survived resume");

endmodule // wpc_top
`default_nettype wire
